// ### hdl/fp_class_pkg.sv
// Constants and types for the floating-point operand classifier and NaN selector
// How it works
// RL1: Two widths: 32-bit single, 64-bit double
// RL2: Exponent field 8 bits single, 11 double
// RL3: True exponent is stored minus 127/1023
// RL4: Implied unit bit one normal, zero denormal
// RL5: All-ones exponent special, all-zeros zero/denormal
// RL6: Normalized when exponent 1..254 or 1..2046
// RL7: Zero class; plus and minus zero compare equal
// RL8: Denormal: zero exponent, nonzero fraction, minimum exponent
// RL9: Infinity: maximum exponent 255/2047, zero fraction
// RL10: Infinity arithmetic exact, no exception unless invalid
// RL11: NaN signaling if top fraction bit zero
// RL12: NaN sign ignored for classification
// RL13: Signaling NaN operand raises exception indication
// RL14: Disabled invalid operation yields quiet NaN
// RL15: Convert-to-integer upper word is fff80000
// RL16: Status read undefined upper half gets quiet NaN
// RL17: Quiet NaNs pass silently except ordered compare, convert
// RL18: NaN result from first used A, B, C
// RL19: Generated NaN: sign zero, ones exponent, top bit
// RL20: Exactly one class per operand plus sign
package fp_class_pkg;
  // ==========================================================
  // Format layout
  localparam int DBL_WIDTH   = 64;          // Double format width
  localparam int SGL_WIDTH   = 32;          // Single format width
  localparam int DBL_EXP_W   = 11;          // Double exponent width
  localparam int SGL_EXP_W   = 8;           // Single exponent width
  localparam int DBL_FRAC_W  = 52;          // Double fraction width
  localparam int SGL_FRAC_W  = 23;          // Single fraction width
  localparam int DBL_EXP_LSB = 52;          // Double exponent position
  localparam int SGL_EXP_LSB = 23;          // Single exponent position
  localparam int TEXP_W      = 13;          // Signed true exponent width
  localparam logic [12:0] DBL_BIAS = 13'h03ff; // 1023
  localparam logic [12:0] SGL_BIAS = 13'h007f; // 127
  localparam logic [12:0] DBL_EMIN = 13'h1c02; // -1022
  localparam logic [12:0] SGL_EMIN = 13'h1f82; // -126
  localparam logic [10:0] DBL_EXP_MAX = 11'h7ff; // 2047
  localparam logic [7:0]  SGL_EXP_MAX = 8'hff;   // 255
  // ==========================================================
  // Fixed NaN patterns
  localparam logic [63:0] DEFAULT_QNAN   = 64'h7ff8000000000000; // Generated NaN
  localparam logic [31:0] CVT_UPPER_QNAN = 32'hfff80000;         // Convert upper word
  localparam logic [31:0] STATUS_UPPER_QNAN = 32'hfff80000;      // Status read upper word
  // ==========================================================
  // Operand classes, exactly one per operand
  typedef enum logic [2:0] {
    CLS_ZERO, CLS_DENORM, CLS_NORM, CLS_INF, CLS_SNAN, CLS_QNAN
  } fp_class_t;
  // Operation kinds the selector cares about
  typedef enum logic [2:0] {
    OP_ARITH, OP_CMP_ORDERED, OP_CMP_UNORDERED, OP_CVT_INT, OP_STATUS_READ
  } fp_op_kind_t;
endpackage : fp_class_pkg

// ### hdl/fp_class_if.sv
// Interface carrying one operand's classification between design modules
interface fp_class_if;
  import fp_class_pkg::*;
  logic [63:0]        operand;    // Raw double-format bits
  logic               single;     // Operand is single format
  fp_class_t          cls;        // Operand class
  logic               sign;       // Sign, zero for NaNs
  logic               is_nan;     // Any NaN
  logic [12:0]        true_exp;   // Unbiased exponent
  logic [52:0]        significand;// Unit bit and fraction
  modport classifier (input operand, input single,
                      output cls, output sign, output is_nan, output true_exp,
                      output significand);
  modport user (output operand, output single,
                input cls, input sign, input is_nan, input true_exp,
                input significand);
endinterface : fp_class_if

// ### hdl/fp_operand_classify.sv
// Combinational classifier for one single- or double-format operand
module fp_operand_classify
  import fp_class_pkg::*;
(
  fp_class_if.classifier port_c  // Operand in, class out
);
  logic        s;        // Sign bit
  logic [10:0] e;        // Biased exponent field
  logic [51:0] f;        // Fraction, left aligned
  logic        e_max;    // All ones
  logic        e_zero;   // All zeros
  // ==========================================================
  // Field extraction and class decode
  always_comb begin
    s = port_c.operand[DBL_WIDTH-1];
    if (port_c.single) begin                           // RL1
      e = {3'h0, port_c.operand[SGL_EXP_LSB +: SGL_EXP_W]}; // RL2
      f = {port_c.operand[SGL_FRAC_W-1:0], 29'h0};
      e_max = (e[7:0] == SGL_EXP_MAX);                  // RL9
    end else begin
      e = port_c.operand[DBL_EXP_LSB +: DBL_EXP_W];     // RL2
      f = port_c.operand[DBL_FRAC_W-1:0];
      e_max = (e == DBL_EXP_MAX);                       // RL9
    end
    e_zero = (e == 11'h000);                            // RL5
    if (e_max) begin                                    // RL5
      if (f == 52'h0) port_c.cls = CLS_INF;             // RL9
      else if (f[51]) port_c.cls = CLS_QNAN;            // RL11
      else port_c.cls = CLS_SNAN;                       // RL11
    end else if (e_zero) begin
      port_c.cls = (f == 52'h0) ? CLS_ZERO : CLS_DENORM; // RL7 RL8
    end else begin
      port_c.cls = CLS_NORM;                            // RL6
    end
    port_c.is_nan = e_max && (f != 52'h0);
    port_c.sign = s && !port_c.is_nan;                  // RL12
    port_c.significand = {!e_zero, f};                  // RL4
    if (e_zero)
      port_c.true_exp = port_c.single ? SGL_EMIN : DBL_EMIN; // RL8
    else
      port_c.true_exp = {2'h0, e} - (port_c.single ? SGL_BIAS : DBL_BIAS); // RL3
  end
endmodule : fp_operand_classify

// ### hdl/fp_operand_classify_nan_select.sv
// Top: registered classification of three operands and NaN result selection
module fp_operand_classify_nan_select
  import fp_class_pkg::*;
(
  input  wire logic        mclk,              // Core clock, 25 MHz
  input  wire logic        reset,             // Synchronous, active high
  input  wire logic        op_valid,          // Operation presented this cycle
  input  wire fp_op_kind_t op_kind,           // Kind of operation
  input  wire logic        op_single,         // Operands in single format
  input  wire logic [63:0] fp_operand_a,      // Operand A
  input  wire logic [63:0] fp_operand_b,      // Operand B
  input  wire logic [63:0] fp_operand_c,      // Operand C
  input  wire logic        use_a,             // Instruction uses A
  input  wire logic        use_b,             // Instruction uses B
  input  wire logic        use_c,             // Instruction uses C
  input  wire logic        invalid_op,        // Pipeline found an invalid case
  input  wire logic        invalid_op_enable, // Invalid-operation trap enable
  input  wire logic [31:0] low_word,          // Low word for convert or status read
  input  wire logic        upper_undefined,   // Status read upper half undefined
  output logic             res_valid,         // Results below are valid
  output fp_class_t        class_a,           // Class of A
  output fp_class_t        class_b,           // Class of B
  output fp_class_t        class_c,           // Class of C
  output logic             sign_a,            // Sign of A
  output logic             sign_b,            // Sign of B
  output logic             sign_c,            // Sign of C
  output logic [12:0]      exp_a,             // True exponent of A
  output logic [52:0]      sig_a,             // Significand of A
  output logic             cmp_zero_equal,    // A and B both zero
  output logic             snan_exc,          // Signaling NaN operand seen
  output logic             invalid_exc,       // Invalid-op exception raised
  output logic             invalid_trap,      // Invalid op with trap enabled
  output logic             nan_result,        // fp_destination is a forced NaN
  output logic [63:0]      fp_destination     // Result written to register file
);
  // ==========================================================
  // Operand layout and timing
  // A single operand keeps its sign in bit 63 and exponent and fraction
  // in bits 30:0, so one classifier serves both formats; bits 62:31 are
  // ignored, which is a packing the pipeline must honour.
  // Operands are taken on a rising edge with op_valid high and every
  // output moves on that same edge: flags pulse once per operation while
  // classes and result hold until the next one.
  // NaN choice is made for arithmetic only; unused operands need their
  // use bits low or a stale NaN there would win the priority.

  // ==========================================================
  // Classifiers
  fp_class_if ca ();
  fp_class_if cb ();
  fp_class_if cc ();
  assign ca.operand = fp_operand_a;
  assign cb.operand = fp_operand_b;
  assign cc.operand = fp_operand_c;
  assign ca.single  = op_single;
  assign cb.single  = op_single;
  assign cc.single  = op_single;
  fp_operand_classify u_cls_a (.port_c(ca.classifier));  // RL20
  fp_operand_classify u_cls_b (.port_c(cb.classifier));  // RL20
  fp_operand_classify u_cls_c (.port_c(cc.classifier));  // RL20

  // ==========================================================
  // Registered state
  typedef struct packed {
    logic        valid;
    fp_class_t   ca, cb, cc;
    logic        sa, sb, sc;
    logic [12:0] ea;
    logic [52:0] ga;
    logic        zeq;
    logic        snan;
    logic        inv;
    logic        trap;
    logic        nan;
    logic [63:0] dest;
  } state_t;
  state_t st;       // Current
  state_t next_st;  // Next

  // Widen a single-format NaN to double, keeping payload
  function automatic logic [63:0] to_double_nan(input logic [63:0] v, input logic sgl);
    if (sgl)
      to_double_nan = {v[DBL_WIDTH-1], DBL_EXP_MAX, v[22:0], 29'h0};
    else
      to_double_nan = v;
  endfunction : to_double_nan

  logic        a_nan, b_nan, c_nan;  // Used NaN operands
  logic        any_snan;             // Used signaling NaN
  logic        any_qnan;             // Used quiet NaN
  logic        q_trips;              // Quiet NaN trips on this kind
  logic        inv_all;              // Total invalid condition

  // ==========================================================
  // Next-state: classes, exceptions and NaN choice
  always_comb begin
    next_st = st;
    a_nan = use_a && ca.is_nan;
    b_nan = use_b && cb.is_nan;
    c_nan = use_c && cc.is_nan;
    any_snan = (use_a && ca.cls == CLS_SNAN) || (use_b && cb.cls == CLS_SNAN)
             || (use_c && cc.cls == CLS_SNAN);
    any_qnan = (a_nan || b_nan || c_nan) && !any_snan;
    // Quiet NaNs are silent except in ordered compare and convert
    q_trips = (op_kind == OP_CMP_ORDERED) || (op_kind == OP_CVT_INT); // RL17
    // Infinities alone never raise here; only pipeline-flagged cases do
    inv_all = invalid_op || any_snan || (any_qnan && q_trips);        // RL10
    next_st.valid = op_valid;
    if (op_valid) begin
      next_st.ca = ca.cls;
      next_st.cb = cb.cls;
      next_st.cc = cc.cls;
      next_st.sa = ca.sign;
      next_st.sb = cb.sign;
      next_st.sc = cc.sign;
      next_st.ea = ca.true_exp;
      next_st.ga = ca.significand;
      next_st.zeq = (ca.cls == CLS_ZERO) && (cb.cls == CLS_ZERO); // RL7
      next_st.snan = any_snan && op_kind != OP_STATUS_READ;       // RL13
      next_st.inv = inv_all && op_kind != OP_STATUS_READ;
      next_st.trap = next_st.inv && invalid_op_enable;
      next_st.nan = 1'b0;
      next_st.dest = 64'h0;
      if (op_kind == OP_CVT_INT) begin
        next_st.dest = {CVT_UPPER_QNAN, low_word};                // RL15
      end else if (op_kind == OP_STATUS_READ) begin
        next_st.dest = {upper_undefined ? STATUS_UPPER_QNAN : 32'h0, low_word}; // RL16
      end else if (op_kind == OP_ARITH) begin
        if (a_nan) begin                                          // RL18
          next_st.dest = to_double_nan(fp_operand_a, op_single) | 64'h0008000000000000;
          next_st.nan = 1'b1;
        end else if (b_nan) begin                                 // RL18
          next_st.dest = to_double_nan(fp_operand_b, op_single) | 64'h0008000000000000;
          next_st.nan = 1'b1;
        end else if (c_nan) begin                                 // RL18
          next_st.dest = to_double_nan(fp_operand_c, op_single) | 64'h0008000000000000;
          next_st.nan = 1'b1;
        end else if (invalid_op && !invalid_op_enable) begin      // RL14
          next_st.dest = DEFAULT_QNAN;                            // RL19
          next_st.nan = 1'b1;
        end
      end
    end else begin
      next_st.snan = 1'b0;
      next_st.inv = 1'b0;
      next_st.trap = 1'b0;
      next_st.nan = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '{valid: 1'b0, ca: CLS_ZERO, cb: CLS_ZERO, cc: CLS_ZERO,
              sa: 1'b0, sb: 1'b0, sc: 1'b0, ea: 13'h0, ga: 53'h0, zeq: 1'b0,
              snan: 1'b0, inv: 1'b0, trap: 1'b0, nan: 1'b0, dest: 64'h0};
    end else begin
      st <= next_st;
    end
  end

  assign res_valid      = st.valid;
  assign class_a        = st.ca;
  assign class_b        = st.cb;
  assign class_c        = st.cc;
  assign sign_a         = st.sa;
  assign sign_b         = st.sb;
  assign sign_c         = st.sc;
  assign exp_a          = st.ea;
  assign sig_a          = st.ga;
  assign cmp_zero_equal = st.zeq;
  assign snan_exc       = st.snan;
  assign invalid_exc    = st.inv;
  assign invalid_trap   = st.trap;
  assign nan_result     = st.nan;
  assign fp_destination = st.dest;

  // ==========================================================
  // Checks
  // Each check looks one edge after the operands were taken, since
  // classes, flags and result all leave the state register.
  // Antecedents built on s_dbl_take and s_sgl_take read operand pins, so a
  // broken classifier cannot excuse itself there through its own outputs.
  default clocking core_clk @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Operation steps shared by several checks
  sequence s_arith_take;
    op_valid && op_kind == OP_ARITH;
  endsequence

  sequence s_dbl_take;
    op_valid && !op_single;
  endsequence

  sequence s_sgl_take;
    op_valid && op_single;
  endsequence

  // A used signaling NaN on A flags in arithmetic
  a_snan_raises: assert property ( // RL13
    (s_arith_take ##0 (use_a && ca.cls == CLS_SNAN)) |=> snan_exc)
    else $error("signaling NaN did not raise");

  // Quiet NaNs pass arithmetic silently, not conversion
  a_qnan_silent: assert property ( // RL17
    (s_arith_take ##0 (!invalid_op && !any_snan)) |=> !invalid_exc)
    else $error("quiet NaN raised exception");
  a_cvt_trips: assert property ( // RL17
    (op_valid && op_kind == OP_CVT_INT && any_qnan) |=> invalid_exc)
    else $error("convert passed a quiet NaN");

  // Operand A wins the NaN priority
  a_first_nan_a: assert property ( // RL18
    (s_arith_take ##0 (a_nan && !op_single))
      |=> fp_destination == ($past(fp_operand_a) | 64'h0008000000000000))
    else $error("A NaN not chosen first");

  // B wins only when A is no NaN
  a_first_nan_b: assert property ( // RL18
    (s_arith_take ##0 (!a_nan && b_nan && !op_single))
      |=> fp_destination == ($past(fp_operand_b) | 64'h0008000000000000))
    else $error("B NaN not chosen second");

  // C is the last operand considered
  a_first_nan_c: assert property ( // RL18
    (s_arith_take ##0 (!a_nan && !b_nan && c_nan && !op_single))
      |=> fp_destination == ($past(fp_operand_c) | 64'h0008000000000000))
    else $error("C NaN not chosen third");

  // Single NaNs widen, keeping sign and payload
  a_single_widen: assert property ( // RL18
    (s_arith_take ##0 (a_nan && op_single))
      |=> fp_destination == ({$past(fp_operand_a[63]), DBL_EXP_MAX,
                              $past(fp_operand_a[22:0]), 29'h0} | 64'h0008000000000000))
    else $error("single NaN widened wrong");

  // A forced NaN result is always quiet
  a_nan_quiet: assert property ( // RL18
    nan_result |-> fp_destination[51])
    else $error("forced NaN not quiet");

  // Generated NaN when nothing propagates
  a_default_qnan: assert property ( // RL19
    (s_arith_take ##0 (!a_nan && !b_nan && !c_nan && invalid_op && !invalid_op_enable))
      |=> fp_destination == DEFAULT_QNAN)
    else $error("default NaN wrong");

  // Convert always fills the upper word
  a_cvt_upper: assert property ( // RL15
    (op_valid && op_kind == OP_CVT_INT) |=> fp_destination[63:32] == CVT_UPPER_QNAN)
    else $error("convert upper word wrong");

  // Undefined status half reads as quiet NaN
  a_status_upper: assert property ( // RL16
    (op_valid && op_kind == OP_STATUS_READ && upper_undefined)
      |=> fp_destination[63:32] == STATUS_UPPER_QNAN)
    else $error("status upper half wrong");

  // NaN sign dropped on A and B
  a_nan_no_sign: assert property ( // RL12
    (res_valid && (class_a == CLS_QNAN || class_a == CLS_SNAN)) |-> !sign_a)
    else $error("NaN carried a sign");
  a_nan_sign_b: assert property ( // RL12
    (res_valid && (class_b == CLS_QNAN || class_b == CLS_SNAN)) |-> !sign_b)
    else $error("NaN on B carried a sign");

  // Top biased exponent is still normal
  a_norm_range: assert property ( // RL6
    (s_dbl_take ##0 (fp_operand_a[62:52] == 11'h7fe)) |=> class_a == CLS_NORM)
    else $error("top exponent not normal");

  // Exponent equal to the bias is true zero
  a_dbl_bias: assert property ( // RL3
    (s_dbl_take ##0 (fp_operand_a[62:52] == 11'h3ff)) |=> exp_a == 13'h0)
    else $error("double bias wrong");
  a_sgl_bias: assert property ( // RL3
    (s_sgl_take ##0 (fp_operand_a[30:23] == 8'h7f)) |=> exp_a == 13'h0)
    else $error("single bias wrong");

  // Unit bit set for normal, clear for zero and denormal
  a_unit_bit: assert property ( // RL4
    (res_valid && class_a inside {CLS_ZERO, CLS_DENORM, CLS_NORM})
      |-> sig_a[52] == (class_a == CLS_NORM))
    else $error("unit bit wrong");

  // Denormals take the minimum exponent
  a_denorm_exp: assert property ( // RL8
    (s_dbl_take ##0 (fp_operand_a[62:52] == 11'h000 && fp_operand_a[51:0] != 52'h0))
      |=> class_a == CLS_DENORM && exp_a == DBL_EMIN)
    else $error("denormal decode wrong");

  // Maximum exponent splits infinity and both NaN kinds
  a_inf_nan_kind: assert property ( // RL9 RL11
    (s_dbl_take ##0 (fp_operand_a[62:52] == DBL_EXP_MAX))
      |=> class_a == ($past(fp_operand_a[51:0]) == 52'h0 ? CLS_INF
                     : $past(fp_operand_a[51]) ? CLS_QNAN : CLS_SNAN))
    else $error("maximum exponent decode wrong");

  // Signed zeros compare equal
  a_zero_equal: assert property ( // RL7
    (s_dbl_take ##0 (fp_operand_a[62:0] == 63'h0 && fp_operand_b[62:0] == 63'h0))
      |=> cmp_zero_equal)
    else $error("signed zeros unequal");

  // Every taken operation answers next cycle, idle raises nothing
  a_res_follows: assert property ( // RL20
    op_valid |=> res_valid)
    else $error("result strobe missing");
  a_flags_idle: assert property ( // RL20
    !op_valid |=> !res_valid && !snan_exc && !invalid_exc && !nan_result)
    else $error("flag without operation");

  // Trap only with the enable set, and only on an exception
  a_trap_gate: assert property ( // RL14
    (op_valid && !invalid_op_enable) |=> !invalid_trap)
    else $error("trap while disabled");
  a_trap_exc: assert property ( // RL14
    invalid_trap |-> invalid_exc)
    else $error("trap without invalid");
endmodule : fp_operand_classify_nan_select

// ### dv/fp_regfile_model.sv
// Register-file model that stores every result the classifier delivers
module fp_regfile_model
  import fp_class_pkg::*;
(
  input  wire logic        mclk,       // Core clock
  input  wire logic        reset,      // Synchronous, active high
  input  wire logic        res_valid,  // Result strobe
  input  wire logic [63:0] wr_data,    // Result word
  output logic [63:0]      last_write, // Most recent stored word
  output int               n_writes    // Results taken so far
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Write port
  // Takes a word on every strobe; no back-pressure exists on this path
  always @(posedge mclk) begin
    if (reset) begin
      n_writes   <= 0;
      last_write <= ~last_write; // Stale contents never look valid
    end else if (res_valid) begin
      last_write <= wr_data;
      n_writes   <= n_writes + 1;
    end
  end
endmodule : fp_regfile_model

// ### dv/fp_operand_classify_nan_select_tb_top.sv
// Self-checking bench for the operand classifier and NaN selector
module fp_operand_classify_nan_select_tb_top
  import fp_class_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observed signals
  logic mclk = 0, reset = 1, op_valid = 0, op_single = 0, use_a = 0, use_b = 0, use_c = 0;
  logic invalid_op = 0, invalid_op_enable = 0, upper_undefined = 0;
  fp_op_kind_t op_kind = OP_ARITH;         // Operation kind
  logic [63:0] fp_operand_a = '0, fp_operand_b = '0, fp_operand_c = '0;
  logic [31:0] low_word = '0;             // Low word for convert/status
  logic res_valid, sign_a, sign_b, sign_c, cmp_zero_equal, snan_exc, invalid_exc;
  logic invalid_trap, nan_result;
  fp_class_t class_a, class_b, class_c;   // Reported classes
  logic [12:0] exp_a;                     // True exponent of A
  logic [52:0] sig_a;                     // Significand of A
  logic [63:0] fp_destination, last_write;
  int n_writes, n_errors = 0, total_checks = 0, n_ops = 0;
  // Expected values of the op now in flight
  int e_cls[3];
  logic e_sgn[3];
  logic e_v, e_snan, e_exc, e_trap, e_nan, e_dchk, e_zchk, e_achk;
  logic [63:0] e_dest, e_exp, e_sig;
  always #20 mclk = ~mclk;                // 25 MHz core clock
  fp_operand_classify_nan_select dut (.mclk(mclk), .reset(reset), .op_valid(op_valid),
    .op_kind(op_kind), .op_single(op_single), .fp_operand_a(fp_operand_a),
    .fp_operand_b(fp_operand_b), .fp_operand_c(fp_operand_c), .use_a(use_a), .use_b(use_b),
    .use_c(use_c), .invalid_op(invalid_op), .invalid_op_enable(invalid_op_enable),
    .low_word(low_word), .upper_undefined(upper_undefined), .res_valid(res_valid),
    .class_a(class_a), .class_b(class_b), .class_c(class_c), .sign_a(sign_a),
    .sign_b(sign_b), .sign_c(sign_c), .exp_a(exp_a), .sig_a(sig_a),
    .cmp_zero_equal(cmp_zero_equal), .snan_exc(snan_exc), .invalid_exc(invalid_exc),
    .invalid_trap(invalid_trap), .nan_result(nan_result), .fp_destination(fp_destination));
  fp_regfile_model regs (.mclk(mclk), .reset(reset), .res_valid(res_valid),
    .wr_data(fp_destination), .last_write(last_write), .n_writes(n_writes));
  // ==========================================================
  // Reference model: class code 0..5 in the enum's order
  function automatic int cls_of(input logic [63:0] v, input logic s);
    int e, emax;
    logic [51:0] f;
    emax = s ? 255 : 2047;
    e = s ? int'(v[30:23]) : int'(v[62:52]);
    f = s ? {v[22:0], 29'h0} : v[51:0];   // Single fraction left-aligned
    if (e == 0) return (f == 0) ? 0 : 1;
    if (e < emax) return 2;
    if (f == 0) return 3;
    return f[51] ? 5 : 4;
  endfunction : cls_of
  // Builds an operand of class c, boundary exponents favoured
  function automatic logic [63:0] mk(input int c, input logic s);
    int e, emax;
    logic [51:0] f;
    emax = s ? 255 : 2047;
    e = (c < 2) ? 0 : (c > 2) ? emax : $urandom_range(0, 1) ? $urandom_range(1, 2) * (emax - 1) / 2 + 1 - ($urandom_range(0, 1)) : emax - 1;
    e = (c == 2 && (e < 1 || e > emax - 1)) ? 1 : e;
    f = {$urandom, $urandom};
    if (c == 0 || c == 3) f = '0;
    if (c == 1 || c == 4) f[29] = 1'b1;   // Nonzero in both formats
    if (c == 4) f[51] = 1'b0;
    if (c == 5) f[51] = 1'b1;
    return s ? {f[0], 32'h0, e[7:0], f[51:29]} : {f[0], e[10:0], f};
  endfunction : mk
  // One comparison, counted
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    total_checks++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // ==========================================================
  // Drive one random op (or idle) and work out what must come back
  task automatic drive();
    logic [63:0] o[3], pick;
    logic u[3], s, sn, qn, fnd;
    int te;
    s = ($urandom_range(0, 3) == 0);
    {sn, qn, fnd, pick} = '0;
    op_kind = fp_op_kind_t'($urandom_range(0, 4));
    for (int k = 0; k < 3; k++) begin
      o[k] = mk($urandom_range(0, 5), s);
      u[k] = $urandom;
      e_cls[k] = cls_of(o[k], s);
      e_sgn[k] = (e_cls[k] >= 4) ? 1'b0 : o[k][63];
      sn |= u[k] && e_cls[k] == 4;
      qn |= u[k] && e_cls[k] == 5;
      if (u[k] && e_cls[k] >= 4 && !fnd) begin
        fnd = 1;
        pick = (s ? {o[k][63], 11'h7ff, o[k][22:0], 29'h0} : o[k]) | 64'h0008000000000000;
      end
    end
    op_valid = ($urandom_range(0, 4) != 0);
    {fp_operand_a, fp_operand_b, fp_operand_c} = {o[0], o[1], o[2]};
    {use_a, use_b, use_c, op_single} = {u[0], u[1], u[2], s};
    invalid_op = (op_kind != OP_STATUS_READ) && ($urandom_range(0, 3) == 0);
    invalid_op_enable = (sn | qn) ? 1'b0 : 1'($urandom);
    low_word = $urandom;
    upper_undefined = $urandom;
    e_v = op_valid;
    e_snan = op_valid && op_kind != OP_STATUS_READ && sn;
    e_exc = op_valid && op_kind != OP_STATUS_READ && (invalid_op || sn ||
            (qn && (op_kind == OP_CMP_ORDERED || op_kind == OP_CVT_INT)));
    e_trap = e_exc && invalid_op_enable;
    e_nan = op_valid && op_kind == OP_ARITH && (fnd || (invalid_op && !invalid_op_enable));
    e_dchk = e_nan || op_kind inside {OP_CVT_INT, OP_STATUS_READ};
    e_dest = e_nan ? (fnd ? pick : 64'h7ff8000000000000) :
             {(op_kind == OP_CVT_INT || upper_undefined) ? 32'hfff80000 : 32'h0, low_word};
    e_zchk = op_kind inside {OP_CMP_ORDERED, OP_CMP_UNORDERED};
    e_achk = e_cls[0] <= 2;
    te = (e_cls[0] != 2) ? (s ? -126 : -1022) :
         s ? int'(o[0][30:23]) - 127 : int'(o[0][62:52]) - 1023;
    e_exp = {51'h0, te[12:0]};
    e_sig = s ? {11'h0, e_cls[0] == 2, o[0][22:0], 29'h0} :
                {11'h0, e_cls[0] == 2, o[0][51:0]};
    n_ops += op_valid;
  endtask : drive
  // Compare outputs of the op taken at the last edge
  task automatic check();
    chk(res_valid, e_v);
    chk(snan_exc, e_snan);
    chk(invalid_exc, e_exc);
    chk(invalid_trap, e_trap);
    chk(nan_result, e_nan);
    if (!e_v) return;
    chk(64'(class_a), 64'(e_cls[0]));
    chk(64'(class_b), 64'(e_cls[1]));
    chk(64'(class_c), 64'(e_cls[2]));
    chk({sign_a, sign_b, sign_c}, {e_sgn[0], e_sgn[1], e_sgn[2]});
    if (e_dchk) chk(fp_destination, e_dest);
    if (e_zchk) chk(cmp_zero_equal, e_cls[0] == 0 && e_cls[1] == 0);
    if (e_achk) chk(64'(exp_a), e_exp);
    if (e_achk) chk(64'(sig_a), e_sig);
  endtask : check
  // ==========================================================
  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // Main sequence: reset, back-to-back random ops, final write count
  initial begin
    void'($urandom(94318));
    repeat (4) @(negedge mclk);
    reset = 0;
    chk({58'h0, res_valid, nan_result, invalid_exc, class_a}, 64'h0);
    for (int i = 0; i < 1500; i++) begin
      @(negedge mclk);
      if (i > 0) check();
      drive();
    end
    @(negedge mclk);
    check();
    op_valid = 0;
    repeat (2) @(negedge mclk);
    chk(64'(n_writes), 64'(n_ops));
    if (e_v && e_dchk) chk(last_write, e_dest);
    tally_and_finish();
  end
endmodule : fp_operand_classify_nan_select_tb_top
